// >>> hw/xbus_arbiter.sv
// Arbiter and peer-repeater end of the expansion bus.
// Assumes one repeater on the interface and one peer on the user ports.
`timescale 1ns/1ps
`include "xbus_regs.svh"
module xbus_arbiter (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // Board strap
  input wire logic BUS_TIMING_SELECT,
  // Peer stream
  input wire logic PEER_REQ,
  input wire logic PEER_BIT,
  input wire logic PEER_FRAME,
  input wire logic PEER_JAM,
  input wire logic STATS_INCLUDE,
  // Status
  output logic PEER_GRANTED,
  output logic MULTI_ACTIVE,
  // Bus
  xbus_if.arb LINK
);

  // ----------------------------------------
  // Request and strap synchroniser
  // ----------------------------------------
  logic [1:0] r1_ff, r2_ff, r3_ff, sync_ff, nxt_sync;

  always_comb begin
    nxt_sync = (r2_ff & r3_ff) | (sync_ff & (r2_ff ^ r3_ff));
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      r1_ff <= 2'h1;
      r2_ff <= 2'h1;
      r3_ff <= 2'h1;
      sync_ff <= 2'h1;
    end else begin
      r1_ff <= {BUS_TIMING_SELECT, LINK.req_n};
      r2_ff <= r1_ff;
      r3_ff <= r2_ff;
      sync_ff <= nxt_sync;
    end
  end

  // ----------------------------------------
  // Grant, multi-active and peer drive
  // ----------------------------------------
  logic dev_req;
  logic ack_ff, nxt_ack;
  logic col_ff, nxt_col;
  logic pdrv_ff, nxt_pdrv;
  logic [4:0] cnt_ff, nxt_cnt;
  logic dat_ff, nxt_dat;
  logic frm_ff, nxt_frm;
  logic clk_ff, nxt_clk;
  logic jam_ff, nxt_jam;

  assign dev_req = ~sync_ff[0];

  always_comb begin
    nxt_ack = dev_req | PEER_REQ;
    nxt_col = dev_req & PEER_REQ;
    nxt_pdrv = PEER_REQ & ~dev_req & ack_ff;
    nxt_cnt = 5'h0;
    nxt_dat = dat_ff;
    nxt_frm = frm_ff;
    nxt_jam = PEER_JAM;
    if (pdrv_ff) begin
      nxt_cnt = (cnt_ff == 5'(`BIT_PER_CYC - 1)) ? 5'h0 : cnt_ff + 5'h1;
      if (cnt_ff == 5'h0) begin
        nxt_dat = PEER_JAM ? 1'b1 : PEER_BIT;
        nxt_frm = PEER_FRAME;
      end
    end else begin
      nxt_frm = 1'b0;
    end
    nxt_clk = (nxt_cnt >= 5'(`BIT_HALF_CYC));
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack_ff <= 1'b0;
      col_ff <= 1'b0;
      pdrv_ff <= 1'b0;
      cnt_ff <= 5'h0;
      dat_ff <= 1'b1;
      frm_ff <= 1'b0;
      clk_ff <= 1'b0;
      jam_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
      col_ff <= nxt_col;
      pdrv_ff <= nxt_pdrv;
      cnt_ff <= nxt_cnt;
      dat_ff <= nxt_dat;
      frm_ff <= nxt_frm;
      clk_ff <= nxt_clk;
      jam_ff <= nxt_jam;
    end
  end

  assign LINK.ack_n = ~ack_ff;
  assign LINK.col_n = ~col_ff;
  assign LINK.stats_include_n = ~STATS_INCLUDE;
  assign LINK.peer_dat_o = dat_ff;
  assign LINK.peer_dat_oe = pdrv_ff;
  assign LINK.peer_jam_o = jam_ff;
  assign LINK.peer_jam_oe = pdrv_ff & ~col_ff;
  assign LINK.peer_clk_o = clk_ff;
  assign LINK.peer_clk_oe = pdrv_ff & sync_ff[1];
  assign LINK.peer_frame_o = ~frm_ff;
  assign LINK.peer_frame_oe = pdrv_ff;
  assign PEER_GRANTED = pdrv_ff;
  assign MULTI_ACTIVE = col_ff;

endmodule : xbus_arbiter

// >>> hw/xbus_if.sv
// Expansion bus wires between a repeater and its arbiter/peer side.
// Resolves shared lines from drive enables; undriven lines rest at the
// level a board termination gives them.
`timescale 1ns/1ps
interface xbus_if;
  logic req_n;
  logic ack_n;
  logic col_n;
  logic stats_include_n;
  logic dev_dat_o, dev_dat_oe, dev_jam_o, dev_jam_oe;
  logic dev_clk_o, dev_clk_oe, dev_frame_o, dev_frame_oe;
  logic peer_dat_o, peer_dat_oe, peer_jam_o, peer_jam_oe;
  logic peer_clk_o, peer_clk_oe, peer_frame_o, peer_frame_oe;
  logic repeated_bit_line;
  logic jam_line;
  logic bus_bit_clock;
  logic frame_n;

  assign repeated_bit_line = dev_dat_oe ? dev_dat_o : (peer_dat_oe ? peer_dat_o : 1'b1);
  assign jam_line = dev_jam_oe ? dev_jam_o : (peer_jam_oe ? peer_jam_o : 1'b0);
  assign bus_bit_clock = dev_clk_oe ? dev_clk_o : (peer_clk_oe ? peer_clk_o : 1'b0);
  assign frame_n = dev_frame_oe ? dev_frame_o : (peer_frame_oe ? peer_frame_o : 1'b1);

  modport dev (
    output req_n, dev_dat_o, dev_dat_oe, dev_jam_o, dev_jam_oe,
    output dev_clk_o, dev_clk_oe, dev_frame_o, dev_frame_oe,
    input ack_n, col_n, stats_include_n,
    input repeated_bit_line, jam_line, bus_bit_clock, frame_n
  );
  modport arb (
    output ack_n, col_n, stats_include_n,
    output peer_dat_o, peer_dat_oe, peer_jam_o, peer_jam_oe,
    output peer_clk_o, peer_clk_oe, peer_frame_o, peer_frame_oe,
    input req_n, repeated_bit_line, jam_line, bus_bit_clock, frame_n
  );
endinterface : xbus_if

// >>> hw/xbus_pkg.sv
// Types used by the repeater end of the expansion bus.
// Assumes nothing beyond the constants header.
package xbus_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_DRIVE
  } tx_state_t;
endpackage : xbus_pkg

// >>> hw/xbus_regs.svh
// Constants for the repeater expansion bus ends: pin slots, bit timing.
// Assumes a 250 MHz core clock and a 10 MHz bus bit clock.
// Operation
// - Requester with grant drives data line, NRZ
// - Grant without own request: data is input
// - No request, no grant: data undriven
// - Collision flag high: data 0 multi, 1 single
// - Active: ports busy, FIFO draining, or extending
// - Active device pulls its request low
// - Sole granted requester drives collision flag
// - Collision flag input on grant, else undriven
// - Arbiter grant permits driving, marks valid data
// - Multi-active from arbiter: each device jams itself
// - Async mode: bit clock out sending, in receiving
// - Sync mode: bit clock line is ignored
// - Statistics-include low counts bus data
// - Envelope marks packet, qualifies async bits
// - Envelope driven only while sending
// - Strap 1 asynchronous, strap 0 synchronous
// - Strap fixed, not changed after reset
// - Device runs from master clock
// - Reset low returns default state
`ifndef XBUS_REGS_SVH
`define XBUS_REGS_SVH

`define CORE_CLK_HZ 250000000
`define BIT_CLK_HZ 10000000
`define BIT_PER_CYC (`CORE_CLK_HZ / `BIT_CLK_HZ)
`define BIT_HALF_CYC (`BIT_PER_CYC / 2)
`define STRAP_INIT_CYC 3'h5

`define SYNC_W 8
`define SYNC_IDLE 8'h67
`define SY_ACK 0
`define SY_COL 1
`define SY_DAT 2
`define SY_JAM 3
`define SY_CLK 4
`define SY_FRM 5
`define SY_STS 6
`define SY_STRAP 7

`endif

// >>> hw/xbus_repeater.sv
// Repeater end of the expansion bus: request, drive, receive, collision.
// Assumes an arbiter on the far side and a board-tied timing strap.
`timescale 1ns/1ps
`include "xbus_regs.svh"
module xbus_repeater (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // Board strap
  input wire logic BUS_TIMING_SELECT,
  // Activity sources
  input wire logic PORT_ACTIVE,
  input wire logic FIFO_BUSY,
  input wire logic EXTENDING,
  // Transmit stream
  input wire logic COLL_STATE,
  input wire logic SINGLE_COLL,
  input wire logic TX_BIT,
  input wire logic TX_FRAME,
  output logic TX_BIT_TAKE,
  // Receive stream
  output logic RX_BIT,
  output logic RX_VALID,
  output logic RX_FRAME,
  output logic RX_JAM,
  output logic RX_MULTI_COLL,
  output logic STATS_COUNT,
  // Status
  output logic JAM_SEQ,
  output logic ASYNC_MODE,
  // Bus
  xbus_if.dev LINK
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [`SYNC_W-1:0] pins;
  logic [`SYNC_W-1:0] s1_ff, s2_ff, s3_ff, filt_ff;
  logic [`SYNC_W-1:0] nxt_filt;

  assign pins = {BUS_TIMING_SELECT, LINK.stats_include_n, LINK.frame_n, LINK.bus_bit_clock,
                 LINK.jam_line, LINK.repeated_bit_line, LINK.col_n, LINK.ack_n};

  always_comb begin
    nxt_filt = (s2_ff & s3_ff) | (filt_ff & (s2_ff ^ s3_ff));
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s1_ff <= `SYNC_IDLE;
      s2_ff <= `SYNC_IDLE;
      s3_ff <= `SYNC_IDLE;
      filt_ff <= `SYNC_IDLE;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      filt_ff <= nxt_filt;
    end
  end

  // ----------------------------------------
  // Mode strap capture
  // ----------------------------------------
  logic [2:0] init_ff, nxt_init;
  logic mode_ff, nxt_mode;

  always_comb begin
    nxt_init = init_ff;
    nxt_mode = mode_ff;
    if (init_ff != `STRAP_INIT_CYC) begin
      nxt_init = init_ff + 3'h1;
      if (init_ff == `STRAP_INIT_CYC - 3'h1) begin
        nxt_mode = filt_ff[`SY_STRAP];
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      init_ff <= 3'h0;
      mode_ff <= 1'b0;
    end else begin
      init_ff <= nxt_init;
      mode_ff <= nxt_mode;
    end
  end

  // ----------------------------------------
  // Request and transmit
  // ----------------------------------------
  logic granted, multi, active;
  logic req_ff, nxt_req;
  xbus_pkg::tx_state_t state_ff, nxt_state;
  logic [4:0] cnt_ff, nxt_cnt;
  logic dat_ff, nxt_dat;
  logic frm_ff, nxt_frm;
  logic take_ff, nxt_take;
  logic clk_ff, nxt_clk;
  logic jam_ff, nxt_jam;
  logic drive;

  assign granted = ~filt_ff[`SY_ACK];
  assign multi = ~filt_ff[`SY_COL];
  assign active = PORT_ACTIVE | FIFO_BUSY | EXTENDING;
  assign drive = (state_ff == xbus_pkg::ST_DRIVE);

  always_comb begin
    nxt_req = active;
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_dat = dat_ff;
    nxt_frm = frm_ff;
    nxt_take = 1'b0;
    nxt_jam = COLL_STATE;
    case (state_ff)
      xbus_pkg::ST_IDLE: begin
        if (req_ff) begin
          nxt_state = xbus_pkg::ST_WAIT;
        end
      end
      xbus_pkg::ST_WAIT: begin
        nxt_cnt = 5'h0;
        if (!req_ff) begin
          nxt_state = xbus_pkg::ST_IDLE;
        end else if (granted) begin
          nxt_state = xbus_pkg::ST_DRIVE;
        end
      end
      xbus_pkg::ST_DRIVE: begin
        if (!req_ff || !granted) begin
          nxt_state = xbus_pkg::ST_IDLE;
          nxt_frm = 1'b0;
        end else begin
          nxt_cnt = (cnt_ff == 5'(`BIT_PER_CYC - 1)) ? 5'h0 : cnt_ff + 5'h1;
          if (cnt_ff == 5'h0) begin
            nxt_dat = COLL_STATE ? SINGLE_COLL : TX_BIT;
            nxt_frm = TX_FRAME;
            nxt_take = 1'b1;
          end
        end
      end
      default: begin
        nxt_state = xbus_pkg::ST_IDLE;
      end
    endcase
    nxt_clk = (nxt_cnt >= 5'(`BIT_HALF_CYC));
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      req_ff <= 1'b0;
      state_ff <= xbus_pkg::ST_IDLE;
      cnt_ff <= 5'h0;
      dat_ff <= 1'b1;
      frm_ff <= 1'b0;
      take_ff <= 1'b0;
      clk_ff <= 1'b0;
      jam_ff <= 1'b0;
    end else begin
      req_ff <= nxt_req;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      dat_ff <= nxt_dat;
      frm_ff <= nxt_frm;
      take_ff <= nxt_take;
      clk_ff <= nxt_clk;
      jam_ff <= nxt_jam;
    end
  end

  assign LINK.req_n = ~req_ff;
  assign LINK.dev_dat_o = dat_ff;
  assign LINK.dev_dat_oe = drive;
  assign LINK.dev_jam_o = jam_ff;
  assign LINK.dev_jam_oe = drive & ~multi;
  assign LINK.dev_clk_o = clk_ff;
  assign LINK.dev_clk_oe = drive & mode_ff;
  assign LINK.dev_frame_o = ~frm_ff;
  assign LINK.dev_frame_oe = drive;
  assign TX_BIT_TAKE = take_ff;
  assign ASYNC_MODE = mode_ff;

  // ----------------------------------------
  // Receive
  // ----------------------------------------
  logic listen, sample;
  logic clk_prev_ff, nxt_clk_prev;
  logic [4:0] rcnt_ff, nxt_rcnt;
  logic rx_bit_ff, nxt_rx_bit;
  logic rx_val_ff, nxt_rx_val;
  logic rx_frm_ff, nxt_rx_frm;
  logic rx_jam_ff, nxt_rx_jam;
  logic rx_mc_ff, nxt_rx_mc;
  logic stats_ff, nxt_stats;
  logic jseq_ff, nxt_jseq;

  assign listen = granted & ~req_ff & ~drive;

  always_comb begin
    nxt_clk_prev = filt_ff[`SY_CLK];
    nxt_rcnt = 5'h0;
    if (!filt_ff[`SY_FRM]) begin
      nxt_rcnt = (rcnt_ff == 5'(`BIT_PER_CYC - 1)) ? 5'h0 : rcnt_ff + 5'h1;
    end
    if (mode_ff) begin
      sample = filt_ff[`SY_CLK] & ~clk_prev_ff & ~filt_ff[`SY_FRM];
    end else begin
      sample = ~filt_ff[`SY_FRM] & (rcnt_ff == 5'(`BIT_HALF_CYC));
    end
    nxt_rx_val = listen & sample;
    nxt_rx_bit = nxt_rx_val ? filt_ff[`SY_DAT] : rx_bit_ff;
    nxt_rx_frm = listen & ~filt_ff[`SY_FRM];
    nxt_rx_jam = listen & filt_ff[`SY_JAM];
    nxt_rx_mc = listen & filt_ff[`SY_JAM] & ~filt_ff[`SY_DAT];
    nxt_stats = listen & sample & ~filt_ff[`SY_STS];
    nxt_jseq = multi & req_ff;
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      clk_prev_ff <= 1'b0;
      rcnt_ff <= 5'h0;
      rx_bit_ff <= 1'b0;
      rx_val_ff <= 1'b0;
      rx_frm_ff <= 1'b0;
      rx_jam_ff <= 1'b0;
      rx_mc_ff <= 1'b0;
      stats_ff <= 1'b0;
      jseq_ff <= 1'b0;
    end else begin
      clk_prev_ff <= nxt_clk_prev;
      rcnt_ff <= nxt_rcnt;
      rx_bit_ff <= nxt_rx_bit;
      rx_val_ff <= nxt_rx_val;
      rx_frm_ff <= nxt_rx_frm;
      rx_jam_ff <= nxt_rx_jam;
      rx_mc_ff <= nxt_rx_mc;
      stats_ff <= nxt_stats;
      jseq_ff <= nxt_jseq;
    end
  end

  assign RX_BIT = rx_bit_ff;
  assign RX_VALID = rx_val_ff;
  assign RX_FRAME = rx_frm_ff;
  assign RX_JAM = rx_jam_ff;
  assign RX_MULTI_COLL = rx_mc_ff;
  assign STATS_COUNT = stats_ff;
  assign JAM_SEQ = jseq_ff;

endmodule : xbus_repeater

// >>> sim/tb_repeater_expansion_bus.sv
// Bench joining repeater and arbiter ends over one interface.
// Assumes the design files and constants header are compiled first.
`timescale 1ns/1ps
module tb_repeater_expansion_bus;
  logic core_clk = 0, rstn = 0, strap = 0;
  logic port_act = 0, fifo_busy = 0, extending = 0, coll_state = 0;
  logic single_coll = 0, tx_bit = 0, tx_frame = 0, peer_req = 0;
  logic peer_bit = 0, peer_frame = 0, stats_incl = 0, peer_jam = 0;
  logic tx_take, rx_bit, rx_valid, rx_frame, stats_cnt, jam_seq, rx_jam, rx_mc;
  logic async_mode, peer_granted, multi_active, b;
  logic q[$];
  int err_count = 0, n_compared = 0, cyc = 0, k, m;
  bit [31:0] seed = 32'h37;
  xbus_if link ();
  xbus_repeater xbus_repeater_inst (.CORE_CLK(core_clk), .RSTN(rstn),
    .BUS_TIMING_SELECT(strap), .PORT_ACTIVE(port_act), .FIFO_BUSY(fifo_busy),
    .EXTENDING(extending), .COLL_STATE(coll_state), .SINGLE_COLL(single_coll),
    .TX_BIT(tx_bit), .TX_FRAME(tx_frame), .TX_BIT_TAKE(tx_take), .RX_BIT(rx_bit),
    .RX_VALID(rx_valid), .RX_FRAME(rx_frame), .RX_JAM(rx_jam), .RX_MULTI_COLL(rx_mc),
    .STATS_COUNT(stats_cnt), .JAM_SEQ(jam_seq), .ASYNC_MODE(async_mode), .LINK(link));
  xbus_arbiter xbus_arbiter_inst (.CORE_CLK(core_clk), .RSTN(rstn),
    .BUS_TIMING_SELECT(strap), .PEER_REQ(peer_req), .PEER_BIT(peer_bit),
    .PEER_FRAME(peer_frame), .PEER_JAM(peer_jam), .STATS_INCLUDE(stats_incl),
    .PEER_GRANTED(peer_granted), .MULTI_ACTIVE(multi_active), .LINK(link));
  xbus_monitor mon_inst (.CORE_CLK(core_clk), .RSTN(rstn), .req_n(link.req_n),
    .ack_n(link.ack_n), .col_n(link.col_n), .dev_dat_oe(link.dev_dat_oe),
    .dev_jam_oe(link.dev_jam_oe), .dev_clk_o(link.dev_clk_o),
    .dev_clk_oe(link.dev_clk_oe), .dev_frame_oe(link.dev_frame_oe),
    .peer_dat_oe(link.peer_dat_oe), .repeated_bit_line(link.repeated_bit_line));
  // ----
  // Clock, timeout, helpers
  // ----
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_count++;
      give_verdict();
    end
  end
  function automatic bit [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task chk(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %b exp %b", $time, got, exp);
    end
  endtask : chk
  task wait_on(input int s);
    int i;
    i = 0;
    do begin
      @(posedge core_clk);
      #1;
      i++;
    end while (!(s == 0 ? tx_take : s == 1 ? rx_valid : jam_seq) && i < 300);
    chk(i < 300, 1'b1);
  endtask : wait_on
  task idle;
    @(posedge core_clk);
    {port_act, fifo_busy, extending, coll_state, peer_req, peer_frame, tx_frame, peer_jam} <= '0;
    repeat (30) @(posedge core_clk);
    #1 chk(link.req_n, 1'b1);
    chk(link.dev_dat_oe, 1'b0);
    chk(link.dev_jam_oe, 1'b0);
  endtask : idle
  task give_verdict;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  // ----
  // Scenarios, sync then async
  // ----
  initial begin
    for (m = 0; m < 2; m++) begin
      @(posedge core_clk);
      rstn <= 0;
      strap <= m[0];
      repeat (2) @(posedge core_clk);
      #1 chk(link.req_n, 1'b1);
      chk(link.dev_dat_oe, 1'b0);
      @(posedge core_clk);
      rstn <= 1;
      repeat (8) @(posedge core_clk);
      #1 chk(async_mode, m[0]);
      for (k = 0; k < 3; k++) begin
        @(posedge core_clk);
        port_act <= k == 0;
        fifo_busy <= k == 1;
        extending <= k == 2;
        repeat (3) @(posedge core_clk);
        #1 chk(link.req_n, 1'b0);
        idle;
      end
      @(posedge core_clk);
      b = 1'(xs());
      q.push_back(b);
      tx_bit <= b;
      tx_frame <= 1;
      port_act <= 1;
      repeat (4) begin
        wait_on(0);
        chk(link.repeated_bit_line, q.pop_front());
        chk(link.frame_n, 1'b0);
        chk(link.dev_clk_oe, m[0]);
        @(posedge core_clk);
        b = 1'(xs());
        q.push_back(b);
        tx_bit <= b;
      end
      q.delete();
      idle;
      for (k = 0; k < 2; k++) begin
        @(posedge core_clk);
        port_act <= 1;
        coll_state <= 1;
        single_coll <= k[0];
        wait_on(0);
        wait_on(0);
        chk(link.jam_line, 1'b1);
        chk(link.repeated_bit_line, k[0]);
        idle;
      end
      @(posedge core_clk);
      port_act <= 1;
      peer_req <= 1;
      wait_on(2);
      chk(multi_active, 1'b1);
      chk(link.col_n, 1'b0);
      idle;
      for (k = 0; k < 4; k++) begin
        @(posedge core_clk);
        b = 1'(xs());
        peer_req <= 1;
        peer_frame <= 1;
        peer_bit <= b;
        peer_jam <= k == 3;
        stats_incl <= k[1];
        wait_on(1);
        wait_on(1);
        chk(rx_bit, k == 3 ? 1'b1 : b);
        chk(rx_jam, k == 3);
        chk(rx_mc, 1'b0);
        chk(stats_cnt, k[1]);
        chk(rx_frame, 1'b1);
        chk(peer_granted, 1'b1);
        chk(link.dev_dat_oe, 1'b0);
        idle;
      end
    end
    give_verdict();
  end
endmodule : tb_repeater_expansion_bus

// >>> sim/xbus_monitor.sv
// Concurrent checks on the expansion bus wires.
// Assumes one repeater and one arbiter share the interface.
`timescale 1ns/1ps
module xbus_monitor (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // Bus wires
  input wire logic req_n,
  input wire logic ack_n,
  input wire logic col_n,
  input wire logic dev_dat_oe,
  input wire logic dev_jam_oe,
  input wire logic dev_clk_o,
  input wire logic dev_clk_oe,
  input wire logic dev_frame_oe,
  input wire logic peer_dat_oe,
  input wire logic repeated_bit_line
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  // ----
  // Assertions
  // ----
  dat_idle_a: assert property ((req_n && ack_n)[*8] |=> !dev_dat_oe)
    else $error("data driven while idle");
  jam_idle_a: assert property ((req_n && ack_n)[*8] |=> !dev_jam_oe)
    else $error("jam driven while idle");
  bit_hold_a: assert property ((dev_dat_oe && $past(dev_dat_oe) && $changed(repeated_bit_line))
    |=> ($stable(repeated_bit_line) || !dev_dat_oe)[*8])
    else $error("data bit not held");
  clk_high_a: assert property (($rose(dev_clk_o) && dev_clk_oe) |=> (dev_clk_o || !dev_clk_oe)[*8])
    else $error("bit clock high phase short");
  req_grant_a: assert property ($fell(req_n) |-> ##[1:10] !ack_n)
    else $error("request not granted");
  multi_grant_a: assert property (!col_n |-> !ack_n)
    else $error("multi active without grant");
  jam_oe_a: assert property (dev_jam_oe |-> dev_dat_oe)
    else $error("jam driven while not sending");
  clk_oe_a: assert property (dev_clk_oe |-> dev_dat_oe)
    else $error("bit clock driven while not sending");
  frame_oe_a: assert property (dev_frame_oe |-> dev_dat_oe)
    else $error("envelope driven while not sending");
  peer_grant_a: assert property (ack_n[*8] |=> !peer_dat_oe)
    else $error("peer drives without grant");
endmodule : xbus_monitor
